// ===== logic/flash_status_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_regs.svh"
module flash_status_host #(
    parameter int unsigned SPACE_CYC = `SPACE_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic [7:0]                paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    output var  logic                      irq,
    output var  flash_host_pkg::flash_ctl_t flash,
    output var  logic [7:0]                dq_o,
    output var  logic                      dq_oe,
    input  wire logic [7:0]                dq_i
);
    localparam int RD_C = `RD_CYC;
    localparam int WP_C = `WP_CYC;

    flash_host_pkg::state_t     state_reg, state_next;
    flash_host_pkg::op_t        op_reg, op_next;
    flash_host_pkg::flash_ctl_t flash_reg, flash_next;
    flash_host_pkg::evt_t       evt;
    logic [1:0]  step_reg, step_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [18:0] addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [7:0]  prev_reg, prev_next;
    logic        recheck_reg, recheck_next;
    logic [7:0]  dq_o_reg, dq_o_next;
    logic        dq_oe_reg, dq_oe_next;
    logic [13:0] space_reg, space_next;
    logic [3:0]  stat_reg, stat_next;
    logic [3:0]  mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [7:0]  dq_s1, dq_s2;
    logic        wr_en, start, toggled, mapped;

    // pin levels for one bus cycle, idle when neither strobe asked
    function automatic flash_host_pkg::flash_ctl_t pins(
        input logic [18:0] a, input logic rd, input logic wr);
        flash_host_pkg::flash_ctl_t c;
        c.addr = a;
        c.ce_n = !(rd || wr);
        c.oe_n = !rd;
        c.we_n = !wr;
        return c;
    endfunction

    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
        is_ofs = (a == o);
    endfunction

    // apb decode; slave never stalls
    assign wr_en = psel && penable && pwrite;
    assign mapped = is_ofs(paddr, `OFS_CTRL) || is_ofs(paddr, `OFS_ADDR) ||
                    is_ofs(paddr, `OFS_WDATA) || is_ofs(paddr, `OFS_RDATA) ||
                    is_ofs(paddr, `OFS_STAT) || is_ofs(paddr, `OFS_MASK);
    assign start = wr_en && is_ofs(paddr, `OFS_CTRL) &&
                   state_reg == flash_host_pkg::S_IDLE;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;
    assign irq = |(stat_reg & mask_reg);
    assign flash = flash_reg;
    assign dq_o = dq_o_reg;
    assign dq_oe = dq_oe_reg;
    assign toggled = rdata_reg[`BIT_GTOG] != prev_reg[`BIT_GTOG];

    // data pins come from outside: two flops before use
    always_ff @(posedge clk) begin
        dq_s1 <= dq_i;
        dq_s2 <= dq_s1;
    end

    // sequencer: flash bus cycles and status algorithms
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        rdata_next = rdata_reg;
        prev_next = prev_reg;
        recheck_next = recheck_reg;
        flash_next = flash_reg;
        dq_o_next = dq_o_reg;
        dq_oe_next = dq_oe_reg;
        space_next = (space_reg == 14'h3fff) ? space_reg : space_reg + 14'h1;
        evt = '0;
        case (state_reg)
            flash_host_pkg::S_IDLE: begin
                if (start) begin
                    op_next = flash_host_pkg::op_t'(pwdata[1:0]);
                    step_next = 2'h0;
                    recheck_next = 1'b0;
                    cnt_next = 8'h0;
                    if (pwdata[1:0] == flash_host_pkg::OP_WRITE ||
                        (pwdata[1:0] == flash_host_pkg::OP_ADD &&
                         pwdata[`BIT_SKIP] &&
                         space_reg < 14'(SPACE_CYC))) begin
                        step_next = 2'h3;
                        state_next = flash_host_pkg::S_WR;
                        flash_next = pins(addr_reg, 1'b0, 1'b1);
                        dq_o_next = wdata_reg;
                        dq_oe_next = 1'b1;
                    end else begin
                        state_next = flash_host_pkg::S_RD;
                        flash_next = pins(addr_reg, 1'b1, 1'b0);
                    end
                end
            end
            flash_host_pkg::S_RD: begin
                cnt_next = cnt_reg + 8'h1;
                // access time plus the two sync stages
                if (cnt_reg == 8'(RD_C - 1)) begin
                    rdata_next = dq_s2;
                    flash_next = pins(addr_reg, 1'b0, 1'b0);
                    cnt_next = 8'h0;
                    state_next = flash_host_pkg::S_GAP;
                end
            end
            flash_host_pkg::S_WR: begin
                cnt_next = cnt_reg + 8'h1;
                if (cnt_reg == 8'(WP_C - 1)) begin
                    flash_next = pins(addr_reg, 1'b0, 1'b0);
                    cnt_next = 8'h0;
                    state_next = flash_host_pkg::S_GAP;
                    if (op_reg == flash_host_pkg::OP_ADD) begin
                        space_next = 14'h0;
                    end
                end
            end
            flash_host_pkg::S_GAP: begin
                // data held past the write strobe, oe high time after reads
                cnt_next = cnt_reg + 8'h1;
                if (cnt_reg == 8'(`GAP_CYC - 1)) begin
                    dq_oe_next = 1'b0;
                    state_next = flash_host_pkg::S_EVAL;
                end
            end
            flash_host_pkg::S_EVAL: begin
                cnt_next = 8'h0;
                state_next = flash_host_pkg::S_IDLE;
                evt.done = 1'b1;
                case (op_reg)
                    flash_host_pkg::OP_POLL: begin
                        // two reads in a row before judging the toggle
                        if (step_reg == 2'h0 ||
                            (toggled && !recheck_reg)) begin
                            recheck_next = step_reg != 2'h0 &&
                                           rdata_reg[`BIT_FAIL];
                            prev_next = rdata_reg;
                            step_next = 2'h1;
                            evt.done = 1'b0;
                            state_next = flash_host_pkg::S_RD;
                            flash_next = pins(addr_reg, 1'b1, 1'b0);
                        end else if (toggled) begin
                            evt.fail = 1'b1;
                        end
                    end
                    flash_host_pkg::OP_ADD: begin
                        if (step_reg == 2'h0) begin
                            if (rdata_reg[`BIT_WIN]) begin
                                evt.closed = 1'b1;
                            end else begin
                                step_next = 2'h1;
                                evt.done = 1'b0;
                                state_next = flash_host_pkg::S_WR;
                                flash_next = pins(addr_reg, 1'b0, 1'b1);
                                dq_o_next = wdata_reg;
                                dq_oe_next = 1'b1;
                            end
                        end else if (step_reg == 2'h1) begin
                            step_next = 2'h2;
                            evt.done = 1'b0;
                            state_next = flash_host_pkg::S_RD;
                            flash_next = pins(addr_reg, 1'b1, 1'b0);
                        end else if (step_reg == 2'h2) begin
                            evt.reject = rdata_reg[`BIT_WIN];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                state_next = flash_host_pkg::S_IDLE;
            end
        endcase
    end

    // register file; a hardware event beats a same-cycle clear
    always_comb begin
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        prdata_next = prdata_reg;
        if (wr_en && is_ofs(paddr, `OFS_ADDR)) begin
            addr_next = pwdata[18:0];
        end
        if (wr_en && is_ofs(paddr, `OFS_WDATA)) begin
            wdata_next = pwdata[7:0];
        end
        if (wr_en && is_ofs(paddr, `OFS_MASK)) begin
            mask_next = pwdata[3:0];
        end
        if (wr_en && is_ofs(paddr, `OFS_STAT)) begin
            stat_next = stat_reg & ~pwdata[3:0];
        end
        stat_next = stat_next | evt;
        // read data captured in setup so it stands through the access
        if (psel && !penable) begin
            case (paddr)
                `OFS_CTRL:  prdata_next = {30'h0, op_reg};
                `OFS_ADDR:  prdata_next = {13'h0, addr_reg};
                `OFS_WDATA: prdata_next = {24'h0, wdata_reg};
                `OFS_RDATA: prdata_next = {23'h0,
                    state_reg != flash_host_pkg::S_IDLE, rdata_reg};
                `OFS_STAT:  prdata_next = {28'h0, stat_reg};
                `OFS_MASK:  prdata_next = {28'h0, mask_reg};
                default:    prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= flash_host_pkg::S_IDLE;
            op_reg <= flash_host_pkg::OP_READ;
            step_reg <= 2'h0;
            cnt_reg <= 8'h0;
            addr_reg <= 19'h0;
            wdata_reg <= 8'h0;
            rdata_reg <= 8'h0;
            prev_reg <= 8'h0;
            recheck_reg <= 1'b0;
            flash_reg <= '{addr: 19'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            dq_o_reg <= 8'h0;
            dq_oe_reg <= 1'b0;
            space_reg <= 14'h3fff;
            stat_reg <= 4'h0;
            mask_reg <= 4'h0;
            prdata_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            prev_reg <= prev_next;
            recheck_reg <= recheck_next;
            flash_reg <= flash_next;
            dq_o_reg <= dq_o_next;
            dq_oe_reg <= dq_oe_next;
            space_reg <= space_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            prdata_reg <= prdata_next;
        end
    end

    // strobe low-time counters, read only by the checks below
    logic [7:0] oe_lo, we_lo;
    always_ff @(posedge clk) begin
        oe_lo <= (srst || flash_reg.oe_n) ? 8'h0 : oe_lo + 8'h1;
        we_lo <= (srst || flash_reg.we_n) ? 8'h0 : we_lo + 8'h1;
    end

    a_no_bus_fight: assert property (@(posedge clk) disable iff (srst)
        !(dq_oe_reg && !flash_reg.oe_n)) else $error("dq driven during read");
    a_strobes_apart: assert property (@(posedge clk) disable iff (srst)
        !(!flash_reg.oe_n && !flash_reg.we_n)) else $error("oe and we low");
    a_read_length: assert property (@(posedge clk) disable iff (srst)
        $rose(flash_reg.oe_n) |-> oe_lo == 8'(RD_C))
        else $error("read strobe length wrong");
    a_write_length: assert property (@(posedge clk) disable iff (srst)
        $rose(flash_reg.we_n) |-> we_lo == 8'(WP_C))
        else $error("write strobe length wrong");
    a_closed_no_write: assert property (@(posedge clk) disable iff (srst)
        evt.closed |=> flash_reg.we_n [*4])
        else $error("sector command written into closed window");
    // the reject must rest on a read that has only just ended
    a_reject_on_flag: assert property (@(posedge clk) disable iff (srst)
        evt.reject |-> rdata_reg[`BIT_WIN] && step_reg == 2'h2 &&
        $past(!flash_reg.oe_n, 4))
        else $error("reject without second flag check");
    a_poll_address: assert property (@(posedge clk) disable iff (srst)
        !flash_reg.oe_n |-> flash_reg.addr == addr_reg)
        else $error("status read at wrong address");
    a_skip_spacing: assert property (@(posedge clk) disable iff (srst)
        $fell(flash_reg.we_n) && op_reg == flash_host_pkg::OP_ADD &&
        step_reg == 2'h3 |-> space_reg < 14'(SPACE_CYC))
        else $error("flag check skipped after spacing expired");
    a_poll_two_reads: assert property (@(posedge clk) disable iff (srst)
        evt.done && op_reg == flash_host_pkg::OP_POLL |-> step_reg == 2'h1)
        else $error("poll finished before two reads");
    a_event_sticky: assert property (@(posedge clk) disable iff (srst)
        evt.done |=> stat_reg[0]) else $error("done status not set");

    c_poll_fail: cover property (@(posedge clk) disable iff (srst)
        evt.fail);
    c_add_reject: cover property (@(posedge clk) disable iff (srst)
        evt.reject);
    c_add_closed: cover property (@(posedge clk) disable iff (srst)
        evt.closed);
endmodule
`default_nettype wire

// ===== logic/flash_host_regs.svh
// Functional notes
// - host may skip flag check only if extra commands are under 50 us apart
// - host confirms acceptance via poll or toggle bit before reading flag; OP_ADD reads the flag without checking either
// - host reads flag before and after each extra sector erase command
// - host reads poll and sector bits at a valid address
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define OFS_CTRL      8'h00
`define OFS_ADDR      8'h04
`define OFS_WDATA     8'h08
`define OFS_RDATA     8'h0c
`define OFS_STAT      8'h10
`define OFS_MASK      8'h14
`define CLK_NS        4
`define T_ACC_NS      150
`define T_WP_NS       50
`define T_OEH_NS      10
`define T_SPACE_NS    50000
`define SYNC_CYC      2
`define RD_CYC        ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_CYC)
`define WP_CYC        ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC       ((`T_OEH_NS + `CLK_NS - 1) / `CLK_NS)
`define SPACE_CYC     (`T_SPACE_NS / `CLK_NS)
`define BIT_POLL      7
`define BIT_GTOG      6
`define BIT_FAIL      5
`define BIT_WIN       3
`define BIT_STOG      2
`define BIT_BUSY      8
`define BIT_SKIP      2
`endif

// ===== logic/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RD   = 5'h02,
        S_WR   = 5'h04,
        S_GAP  = 5'h08,
        S_EVAL = 5'h10
    } state_t;
    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_POLL  = 2'h2,
        OP_ADD   = 2'h3
    } op_t;
    typedef struct packed {
        logic [18:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } flash_ctl_t;
    typedef struct packed {
        logic reject;
        logic closed;
        logic fail;
        logic done;
    } evt_t;
endpackage
`default_nettype wire

// ===== tb/flash_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_device_model #(
    parameter int unsigned WIN_CYC = 600
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire flash_host_pkg::flash_ctl_t flash,
    input  wire logic [7:0]                 dq_bus,
    input  wire logic [1:0]                 mode,
    input  wire logic                       fail,
    input  wire logic                       chip,
    input  wire logic [7:0]                 prog_val,
    input  wire logic [2:0]                 sel_sector,
    output var  logic [7:0]                 dq_drv,
    output var  logic                       dq_en,
    output var  logic [7:0]                 last_wr,
    output var  logic [7:0]                 n_acc
);
    // mode: 0 array, 1 program busy, 2 erase, 3 erase suspended
    // chip: the running erase is a chip erase
    logic        rd, rd_prev, wr_prev, gtog, stog, win_flag, in_sec;
    logic [1:0]  mode_prev;
    int unsigned win_cnt;

    assign rd = !flash.ce_n && !flash.oe_n;
    assign in_sec = flash.addr[18:16] == sel_sector;
    assign dq_en = rd;

    // gtog advances per new read in modes 1 and 2, stog per new in-sector read in modes 2 and 3; window timer per edge
    always @(posedge clk) begin
        rd_prev <= rd;
        wr_prev <= !flash.ce_n && !flash.we_n;
        mode_prev <= mode;
        if (srst) begin
            gtog <= 1'b0;
            stog <= 1'b0;
            win_flag <= 1'b0;
            win_cnt <= 0;
            n_acc <= 8'h00;
            last_wr <= 8'h00;
        end else begin
            if (rd && !rd_prev && (mode == 2'd1 || mode == 2'd2)) begin
                gtog <= !gtog;
            end
            if (rd && !rd_prev && in_sec && mode[1]) begin
                stog <= !stog;
            end
            // chip erase has no acceptance window: flag high at once
            if (chip) begin
                win_flag <= 1'b1;
            end else if (mode == 2'd2 && mode_prev != 2'd2) begin
                win_flag <= 1'b0;
                win_cnt <= 0;
            end else if (mode == 2'd2 && !win_flag) begin
                win_cnt <= win_cnt + 1;
                win_flag <= (win_cnt + 1 >= WIN_CYC);
            end
            // commands after the window closed are dropped silently
            if (wr_prev && flash.we_n) begin
                last_wr <= dq_bus;
                if (mode == 2'd2 && !win_flag) begin
                    n_acc <= n_acc + 8'h01;
                    win_cnt <= 0;
                end
            end
        end
    end

    // undefined positions carry fixed filler, hosts must mask them
    always_comb begin
        dq_drv = flash.addr[7:0] ^ 8'h5a;
        case (mode)
            // program, also program inside erase suspend
            2'd1: begin
                dq_drv = {~prog_val[7], gtog, fail, 2'b00, stog, 2'b01};
            end
            2'd2: begin
                dq_drv = {1'b0, gtog, fail, 1'b0, win_flag, stog, 2'b01};
            end
            2'd3: begin
                if (in_sec) begin
                    dq_drv = {1'b1, gtog, 3'b000, stog, 2'b01};
                end
            end
            default: ;
        endcase
    end
endmodule
`default_nettype wire

// ===== tb/erase_window_status_reporting_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_regs.svh"
module erase_window_status_reporting_test;
    localparam int unsigned WIN = 600;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq;
    logic        dq_oe, dq_en, fail, chip, g, s;
    logic [7:0]  paddr, dq_i, dq_o, dq_last, dq_drv, last_wr, n_acc, p;
    logic [31:0] pwdata, prdata, got;
    logic [1:0]  mode;
    logic [2:0]  sel_sector;
    logic [18:0] a;
    logic [32:0] exp_q[$], msk_q[$], e, m;
    int          errors, n_compared, seed;
    flash_host_pkg::flash_ctl_t flash;

    flash_status_host #(.SPACE_CYC(200)) flash_status_host_i (
        .clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .flash(flash), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    flash_device_model #(.WIN_CYC(WIN)) flash_device_model_i (
        .clk(clk), .srst(srst), .flash(flash), .dq_bus(dq_i),
        .mode(mode), .fail(fail), .chip(chip), .prog_val(p),
        .sel_sector(sel_sector), .dq_drv(dq_drv), .dq_en(dq_en),
        .last_wr(last_wr), .n_acc(n_acc));

    // undriven bus shows a changing pattern, never a stale byte
    assign dq_i = dq_oe ? dq_o : (dq_en ? dq_drv : ~dq_last);
    always @(posedge clk) dq_last <= dq_i;
    always #2 clk = ~clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, want);
        end
    endtask

    task automatic results();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] ad, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        got = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [32:0] want,
                      input logic [32:0] msk);
        exp_q.push_back(want);
        msk_q.push_back(msk);
        apb(ad, 1'b0, 32'h0);
    endtask

    // start an operation and wait for busy to drop, bounded
    task automatic op(input logic [31:0] c);
        int n;
        n = 0;
        apb(`OFS_CTRL, 1'b1, c);
        got = 32'h100;
        while (got[8] !== 1'b0 && n < 600) begin
            n++;
            apb(`OFS_RDATA, 1'b0, 32'h0);
        end
        if (n == 600) errors++;
    endtask

    task automatic byte_rd(input logic [7:0] v, input logic [7:0] mk);
        op(32'h0);
        rd(`OFS_RDATA, {25'h0, v}, {25'h0, mk});
    endtask

    task automatic stat(input logic [3:0] v);
        rd(`OFS_STAT, {29'h0, v}, ALL);
        apb(`OFS_STAT, 1'b1, 32'hf);
    endtask

    // watcher: oldest note against each completed read
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite &&
            exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check({pslverr, prdata} & m, e & m);
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode = 2'd0;
        fail = 1'b0;
        chip = 1'b0;
        p = 8'h00;
        sel_sector = 3'd3;
        dq_last = 8'h00;
        seed = $urandom(48687);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // reset values and the unmapped hole
        rd(`OFS_STAT, 33'h0, ALL);
        rd(`OFS_MASK, 33'h0, ALL);
        rd(8'h18, {1'b1, 32'h0}, ALL);
        repeat (3) begin
            a = 19'($urandom);
            apb(`OFS_ADDR, 1'b1, {13'h0, a});
            rd(`OFS_ADDR, {14'h0, a}, ALL);
            byte_rd(a[7:0] ^ 8'h5a, 8'hff);
            stat(4'h1);
        end
        // plain program write, then the op code and byte read back
        p = 8'($urandom);
        apb(`OFS_WDATA, 1'b1, {24'h0, p});
        rd(`OFS_WDATA, {25'h0, p}, ALL);
        op(32'h1);
        check({25'h0, last_wr}, {25'h0, p});
        rd(`OFS_CTRL, 33'h1, ALL);
        stat(4'h1);
        // program busy: inverted poll bit, global bit flips per read
        p = 8'($urandom);
        mode <= 2'd1;
        g = 1'b0;
        s = 1'b0;
        repeat (2) begin
            g = ~g;
            byte_rd({~p[7], g, 3'b000, s, 2'b00}, 8'he4);
        end
        // first extra sector goes in while the window is open
        mode <= 2'd2;
        apb(`OFS_ADDR, 1'b1, 32'h3_1234);
        p = 8'($urandom);
        apb(`OFS_WDATA, 1'b1, {24'h0, p});
        op(32'h3);
        stat(4'h1);
        check({25'h0, n_acc}, 33'h1);
        check({25'h0, last_wr}, {25'h0, p});
        g = ~g;
        s = ~s;
        byte_rd({1'b0, g, 3'b000, s, 2'b00}, 8'hec);
        repeat (WIN) @(posedge clk);
        g = ~g;
        s = ~s;
        byte_rd({1'b0, g, 3'b001, s, 2'b00}, 8'hec);
        op(32'h3);
        g = ~g;
        s = ~s;
        stat(4'h5);
        // window runs out between the pre-check and the write
        mode <= 2'd1;
        @(posedge clk);
        mode <= 2'd2;
        repeat (WIN - 52) @(posedge clk);
        op(32'h3);
        stat(4'h9);
        check({25'h0, n_acc}, 33'h1);
        // extra sector right away, flag check skipped
        mode <= 2'd1;
        @(posedge clk);
        mode <= 2'd2;
        op(32'h3);
        op(32'h7);
        stat(4'h1);
        check({25'h0, n_acc}, 33'h3);
        // chip erase: flag reads 1 with no acceptance wait
        chip <= 1'b1;
        g = ~g;
        s = ~s;
        byte_rd({1'b0, g, 3'b001, s, 2'b00}, 8'hec);
        chip <= 1'b0;
        // suspended sector shows status, other sectors show data
        mode <= 2'd3;
        repeat (2) begin
            s = ~s;
            byte_rd({1'b1, g, 3'b000, s, 2'b00}, 8'he4);
        end
        a = 19'h5_00a7;
        apb(`OFS_ADDR, 1'b1, {13'h0, a});
        byte_rd(a[7:0] ^ 8'h5a, 8'hff);
        stat(4'h1);
        // timing-limit failure found by the poll, raised on irq
        apb(`OFS_MASK, 1'b1, 32'hf);
        fail <= 1'b1;
        mode <= 2'd1;
        op(32'h2);
        check({32'h0, irq}, 33'h1);
        apb(`OFS_MASK, 1'b1, 32'h0);
        check({32'h0, irq}, 33'h0);
        apb(`OFS_MASK, 1'b1, 32'hf);
        stat(4'h3);
        check({32'h0, irq}, 33'h0);
        // busy ends while polling: done without failure
        fail <= 1'b0;
        fork
            begin
                repeat (300) @(posedge clk);
                mode <= 2'd0;
            end
        join_none
        op(32'h2);
        stat(4'h1);
        results();
    end
endmodule
`default_nettype wire
